//--- logic/sra_regfile.sv
// word array behind the serial register access slave
`timescale 1ns/1ps
module sra_regfile #(
    parameter int DEPTH_W = 6
) (
    input  wire logic               clock,
    input  wire logic               we,
    input  wire logic [DEPTH_W-1:0] wr_idx,
    input  wire logic [15:0]        wr_data,
    input  wire logic [DEPTH_W-1:0] rd_idx,
    output logic      [15:0]        rd_data
);
    generate
        if (DEPTH_W < 1 || DEPTH_W > 15) begin : g_chk
            $error("sra_regfile depth width out of range");
        end
    endgenerate

    logic [15:0] mem_ff [0:(1<<DEPTH_W)-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem_ff[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem_ff[rd_idx];
endmodule // sra_regfile

//--- logic/sra_slave.sv
// two-wire serial register access slave, link and system sides
//
// Behaviour
// - return addressed word as two bytes
// - address-less read uses current word pointer
// - acked read bytes keep data flowing
// - current-address sequential read until host nacks
// - two data bytes stored into addressed word
// - data high byte first, each byte acked
// - sequential write bytes keep being accepted
// - answer 0x78/79 or 0x7A/7B per select pin
// - address byte bit 0 gives direction
// - ninth clock carries ack, nack ends reads
`timescale 1ns/1ps
`include "sra_regs.svh"
module sra_slave #(
    parameter int DEPTH_W = `SRA_DEPTH_W
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             scl,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    input  wire logic             addr_select_pin,
    output logic                  frame_active,
    output sra_pkg::sra_upd_t     upd
);
    generate
        if (DEPTH_W < 1 || DEPTH_W > 15) begin : g_chk
            $error("sra_slave depth width out of range");
        end
        if (`SRA_PTR_STEP != 16'(`SRA_WORD_W / `SRA_BYTE_W)) begin : g_step
            $error("sra_slave pointer step must be one word");
        end
    endgenerate

    // word index of a byte address
    function automatic logic [DEPTH_W-1:0] widx(input logic [15:0] a);
        widx = a[DEPTH_W:1];
    endfunction

    // slave address compare for the selected pair
    function automatic logic dev_match(input logic [7:0] b, input logic sel);
        dev_match = (b[7:1] == (sel ? `SRA_DEV_ADDR_SEL1 : `SRA_DEV_ADDR_SEL0));
    endfunction

    // byte address of the word after a
    function automatic logic [15:0] next_word(input logic [15:0] a);
        next_word = a + `SRA_PTR_STEP;
    endfunction

    // ninth clock of a byte, the acknowledge slot
    function automatic logic ack_slot(input logic [3:0] c);
        ack_slot = (c == `SRA_ACK_SLOT);
    endfunction

    // clock high in both samples while data moves from a to b
    function automatic logic bus_cond(input logic scl_a, input logic scl_b,
                                      input logic sda_a, input logic sda_b);
        bus_cond = scl_a & scl_b & sda_a & ~sda_b;
    endfunction

    // one bit shifted in at the bottom of a byte
    function automatic logic [7:0] shl(input logic [7:0] b, input logic v);
        shl = {b[6:0], v};
    endfunction

    // link state that drives data bytes to the host
    function automatic logic sending(input sra_pkg::sra_lk_st_t s);
        sending = (s == sra_pkg::SRA_LK_RD);
    endfunction

    // ---- system clock side ----
    sra_pkg::sra_sys_t sys_ff;
    sra_pkg::sra_sys_t nxt_sys;
    logic [2:0]        sys_sync;
    logic              scl_s;
    logic              sda_s;
    logic              wtog_s;
    logic              start_det;
    logic              stop_det;
    logic              upd_new;

    // ---- link clock side ----
    sra_pkg::sra_fr_t  fr_ff;
    sra_pkg::sra_fr_t  nxt_fr;
    sra_pkg::sra_pe_t  pe_ff;
    sra_pkg::sra_pe_t  nxt_pe;
    sra_pkg::sra_ne_t  ne_ff;
    sra_pkg::sra_ne_t  nxt_ne;
    logic              link_rst;
    logic              sel_s;
    logic              ack_want;
    logic              wr_en;
    logic [15:0]       ld_addr;
    logic [15:0]       rd_word;
    logic [15:0]       wr_word;

    sra_sync #(
        .W     (3)
    ) u_sys_sync (
        .clock (clock),
        .rst   (rst),
        .d     ({pe_ff.wtog, sda_in, scl}),
        .q     (sys_sync)
    );

    assign scl_s  = sys_sync[0];
    assign sda_s  = sys_sync[1];
    assign wtog_s = sys_sync[2];

    assign start_det = bus_cond(sys_ff.scl_p, scl_s, sys_ff.sda_p, sda_s);
    assign stop_det  = bus_cond(sys_ff.scl_p, scl_s, sda_s, sys_ff.sda_p);
    assign upd_new   = wtog_s ^ sys_ff.wtog_p;

    always_comb begin
        nxt_sys        = sys_ff;
        nxt_sys.scl_p  = scl_s;
        nxt_sys.sda_p  = sda_s;
        nxt_sys.wtog_p = wtog_s;
        // link state held cleared from start or stop until clock goes low
        if (start_det || stop_det) begin
            nxt_sys.clr = 1'b1;
        end else if (!scl_s) begin
            nxt_sys.clr = 1'b0;
        end
        if (start_det) begin
            nxt_sys.active = 1'b1;
        end else if (stop_det) begin
            nxt_sys.active = 1'b0;
        end
        // written word announced once its toggle has crossed
        nxt_sys.upd.valid = upd_new;
        if (upd_new) begin
            nxt_sys.upd.addr = pe_ff.waddr;
            nxt_sys.upd.data = pe_ff.wdata;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sys_ff        <= '0;
            sys_ff.clr    <= `SRA_CLR_RST;
            sys_ff.scl_p  <= `SRA_IDLE_LVL;
            sys_ff.sda_p  <= `SRA_IDLE_LVL;
        end else begin
            sys_ff <= nxt_sys;
        end
    end

    assign frame_active = sys_ff.active;
    assign upd          = sys_ff.upd;

    // ---- link logic ----
    assign link_rst = rst | sys_ff.clr;

    sra_sync #(
        .W     (1)
    ) u_sel_sync (
        .clock (scl),
        .rst   (rst),
        .d     (addr_select_pin),
        .q     (sel_s)
    );

    // word to send next: the pointer, or the next word after a low byte
    assign ld_addr = (sending(fr_ff.st) && fr_ff.lo) ?
                     next_word(pe_ff.ptr) : pe_ff.ptr;
    assign wr_word = {fr_ff.dhi, fr_ff.sh};

    sra_regfile #(
        .DEPTH_W (DEPTH_W)
    ) u_regs (
        .clock   (scl),
        .we      (wr_en),
        .wr_idx  (widx(pe_ff.ptr)),
        .wr_data (wr_word),
        .rd_idx  (widx(ld_addr)),
        .rd_data (rd_word)
    );

    // receiver ack for the ninth clock of a byte
    always_comb begin
        case (fr_ff.st)
            sra_pkg::SRA_LK_DEV: ack_want = dev_match(fr_ff.sh, sel_s);
            sra_pkg::SRA_LK_AHI: ack_want = 1'b1;
            sra_pkg::SRA_LK_ALO: ack_want = 1'b1;
            sra_pkg::SRA_LK_WHI: ack_want = 1'b1;
            sra_pkg::SRA_LK_WLO: ack_want = 1'b1;
            default:             ack_want = 1'b0;
        endcase
    end

    always_comb begin
        nxt_fr = fr_ff;
        nxt_pe = pe_ff;
        wr_en  = 1'b0;
        if (!ack_slot(fr_ff.cnt)) begin
            // data bit, most significant first
            nxt_fr.sh  = shl(fr_ff.sh, sda_in);
            nxt_fr.tx  = shl(fr_ff.tx, 1'b1);
            nxt_fr.cnt = fr_ff.cnt + 4'h1;
        end else begin
            nxt_fr.cnt = `SRA_CNT_RST;
            case (fr_ff.st)
                sra_pkg::SRA_LK_DEV: begin
                    if (!dev_match(fr_ff.sh, sel_s)) begin
                        nxt_fr.st = sra_pkg::SRA_LK_IGN;
                    end else if (fr_ff.sh[`SRA_DIR_BIT]) begin
                        // read starts at the current word pointer
                        nxt_fr.st = sra_pkg::SRA_LK_RD;
                        nxt_fr.tx = rd_word[15:8];
                        nxt_fr.lo = 1'b0;
                    end else begin
                        nxt_fr.st = sra_pkg::SRA_LK_AHI;
                    end
                end
                sra_pkg::SRA_LK_AHI: begin
                    nxt_fr.ahi = fr_ff.sh;
                    nxt_fr.st  = sra_pkg::SRA_LK_ALO;
                end
                sra_pkg::SRA_LK_ALO: begin
                    nxt_pe.ptr = {fr_ff.ahi, fr_ff.sh};
                    nxt_fr.st  = sra_pkg::SRA_LK_WHI;
                end
                sra_pkg::SRA_LK_WHI: begin
                    nxt_fr.dhi = fr_ff.sh;
                    nxt_fr.st  = sra_pkg::SRA_LK_WLO;
                end
                sra_pkg::SRA_LK_WLO: begin
                    // store the word, then expect the next one
                    wr_en        = 1'b1;
                    nxt_pe.waddr = pe_ff.ptr;
                    nxt_pe.wdata = wr_word;
                    nxt_pe.wtog  = ~pe_ff.wtog;
                    nxt_pe.ptr   = next_word(pe_ff.ptr);
                    nxt_fr.st    = sra_pkg::SRA_LK_WHI;
                end
                sra_pkg::SRA_LK_RD: begin
                    if (fr_ff.lo) begin
                        nxt_pe.ptr = next_word(pe_ff.ptr);
                    end
                    if (!sda_in) begin
                        // host ack: supply the next byte
                        nxt_fr.tx = fr_ff.lo ? rd_word[15:8] : rd_word[7:0];
                        nxt_fr.lo = ~fr_ff.lo;
                    end else begin
                        nxt_fr.st = sra_pkg::SRA_LK_IGN;
                    end
                end
                sra_pkg::SRA_LK_IGN: begin
                    nxt_fr.st = sra_pkg::SRA_LK_IGN;
                end
                default: begin
                    nxt_fr.st = sra_pkg::SRA_LK_IGN;
                end
            endcase
        end
    end

    always_ff @(posedge scl or posedge link_rst) begin
        if (link_rst) begin
            fr_ff     <= '0;
            fr_ff.st  <= sra_pkg::SRA_LK_DEV;
            fr_ff.tx  <= 8'hFF;
        end else begin
            fr_ff <= nxt_fr;
        end
    end

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            pe_ff     <= '0;
            pe_ff.ptr <= `SRA_PTR_RST;
        end else begin
            pe_ff <= nxt_pe;
        end
    end

    // data line changes only while the clock is low
    always_comb begin
        nxt_ne     = ne_ff;
        nxt_ne.lvl = 1'b0;
        if (sending(fr_ff.st) && !ack_slot(fr_ff.cnt)) begin
            nxt_ne.oe = ~fr_ff.tx[7];
        end else begin
            nxt_ne.oe = ack_slot(fr_ff.cnt) && ack_want;
        end
    end

    always_ff @(negedge scl or posedge link_rst) begin
        if (link_rst) begin
            ne_ff <= '0;
        end else begin
            ne_ff <= nxt_ne;
        end
    end

    assign sda_oe  = ne_ff.oe;
    assign sda_out = ne_ff.lvl;
endmodule // sra_slave

//--- logic/sra_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
module sra_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    generate
        if (W < 1) begin : g_chk
            $error("sra_sync width must be at least one");
        end
    endgenerate

    logic [1:0][W-1:0] st_ff;
    logic [1:0][W-1:0] nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st[0] = d;
        nxt_st[1] = st_ff[0];
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff[1];
endmodule // sra_sync

//--- shared/sra_pkg.sv
// types of the serial register access slave
package sra_pkg;

typedef enum logic [6:0] {
    SRA_LK_DEV = 7'h01,
    SRA_LK_AHI = 7'h02,
    SRA_LK_ALO = 7'h04,
    SRA_LK_WHI = 7'h08,
    SRA_LK_WLO = 7'h10,
    SRA_LK_RD  = 7'h20,
    SRA_LK_IGN = 7'h40
} sra_lk_st_t;

// link state cleared at every start and stop
typedef struct packed {
    sra_lk_st_t  st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic [7:0]  ahi;
    logic [7:0]  dhi;
    logic        lo;
} sra_fr_t;

// link state kept across frames
typedef struct packed {
    logic [15:0] ptr;
    logic        wtog;
    logic [15:0] waddr;
    logic [15:0] wdata;
} sra_pe_t;

// link state on the falling edge
typedef struct packed {
    logic        oe;
    logic        lvl;
} sra_ne_t;

typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
} sra_upd_t;

typedef struct packed {
    logic        scl_p;
    logic        sda_p;
    logic        wtog_p;
    logic        clr;
    logic        active;
    sra_upd_t    upd;
} sra_sys_t;

endpackage

//--- shared/sra_regs.svh
// constants of the serial register access slave
`ifndef SRA_REGS_SVH
`define SRA_REGS_SVH
`define SRA_WORD_W        16
`define SRA_BYTE_W        8
`define SRA_DEV_ADDR_SEL0 7'h3C
`define SRA_DEV_ADDR_SEL1 7'h3D
`define SRA_DIR_BIT       0
`define SRA_ACK_SLOT      4'h8
`define SRA_CNT_RST       4'h0
`define SRA_PTR_STEP      16'h0002
`define SRA_PTR_RST       16'h0000
`define SRA_CLR_RST       1'b1
`define SRA_IDLE_LVL      1'b1
`define SRA_DEPTH_W       6
`endif

//--- sim/sra_host.sv
// host bus master model driving the serial clock
`timescale 1ns/1ps
module sra_host (
    output logic     scl,
    output logic     hdrv,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        hdrv = 1'b0;
    end

    task automatic xbit(input logic v, output logic r);
        #4 hdrv = !v;
        #20 scl = 1'b1;
        r = sda;
        #24 scl = 1'b0;
    endtask

    task automatic start();
        #4 hdrv = 1'b0;
        #20 scl = 1'b1;
        #24 hdrv = 1'b1;
        #48 scl = 1'b0;
        #20;
    endtask

    task automatic stop();
        #4 hdrv = 1'b1;
        #20 scl = 1'b1;
        #24 hdrv = 1'b0;
        #48;
    endtask

    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(b[i], r);
        xbit(1'b1, r);
        ack = !r;
    endtask

    task automatic rbyte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
        xbit(last, r);
    endtask
endmodule // sra_host

//--- sim/sra_slave_asserts.sv
// assertion checker of the serial register access slave
`timescale 1ns/1ps
module sra_slave_asserts #(
    parameter int DEPTH_W = 6
) (
    input wire logic              clock,
    input wire logic              rst,
    input wire logic              scl,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    input wire logic              addr_select_pin,
    input wire logic              frame_active,
    input wire sra_pkg::sra_upd_t upd
);
    // run of consecutive link slots driven by the device
    logic [3:0] run_ff;

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            run_ff <= 4'h0;
        end else begin
            run_ff <= sda_oe ? run_ff + 4'h1 : 4'h0;
        end
    end

    a_upd_one_pulse: assert property (@(posedge clock) disable iff (rst)
        upd.valid |=> !upd.valid) else $error("update strobe longer than one cycle");
    a_upd_hold_value: assert property (@(posedge clock) disable iff (rst)
        !upd.valid |-> $stable(upd.addr) && $stable(upd.data))
        else $error("update word moved without strobe");
    a_upd_in_frame: assert property (@(posedge clock) disable iff (rst)
        upd.valid |-> frame_active) else $error("word stored outside a frame");
    a_upd_after_ack: assert property (@(posedge clock) disable iff (rst)
        upd.valid |-> $past(sda_oe, 3)) else $error("word stored without acknowledge");
    a_idle_no_drive: assert property (@(posedge clock) disable iff (rst)
        !frame_active |-> !sda_oe) else $error("data line driven outside a frame");
    a_drive_on_low: assert property (@(posedge clock) disable iff (rst)
        $rose(sda_oe) |-> !scl) else $error("data line pulled while clock high");
    a_out_low: assert property (@(posedge clock) disable iff (rst)
        sda_oe |-> !sda_out) else $error("driven data level not low");
    a_stop_ends_frame: assert property (@(posedge clock) disable iff (rst)
        $fell(frame_active) |-> scl && sda_in) else $error("frame ended without stop");
    a_oe_max_nine: assert property (@(posedge scl) disable iff (rst)
        run_ff < 4'hA) else $error("device held data line over nine slots");

    c_word_stored: cover property (@(posedge clock) upd.valid);
    c_frame_end: cover property (@(posedge clock) $fell(frame_active));
    c_zero_byte: cover property (@(posedge scl) run_ff == 4'h9);
endmodule // sra_slave_asserts

bind sra_slave sra_slave_asserts #(.DEPTH_W(DEPTH_W)) sra_slave_asserts_i (
    .clock(clock), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_pin(addr_select_pin), .frame_active(frame_active),
    .upd(upd));

//--- sim/tb_serial_register_access_slave.sv
// self-checking bench of the serial register access slave
`timescale 1ns/1ps
module tb_serial_register_access_slave;
    logic              clock = 1'b0;
    logic              rst = 1'b1;
    logic              addr_select_pin = 1'b0;
    logic              scl;
    logic              hdrv;
    wire               sda;
    logic              sda_out;
    logic              sda_oe;
    logic              frame_active;
    sra_pkg::sra_upd_t upd;
    logic [31:0]       exp_q[$];
    logic [15:0]       mem[logic [15:0]];
    logic [31:0]       seed = 32'h000107BD;
    int                miscompares = 0;
    int                total_checks = 0;
    int                cycles = 0;

    always #5 clock = ~clock;
    assign sda = !(hdrv || (sda_oe && !sda_out));

    sra_slave #(.DEPTH_W(6)) sra_slave_i (.clock(clock), .rst(rst), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(addr_select_pin),
        .frame_active(frame_active), .upd(upd));
    sra_host sra_host_i (.scl(scl), .hdrv(hdrv), .sda(sda));

    function automatic logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction

    function automatic logic [7:0] dev_w();
        return addr_select_pin ? 8'h7A : 8'h78;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] b, input logic exp_ack);
        logic ack;
        sra_host_i.wbyte(b, ack);
        check("ack", {31'h0, ack}, {31'h0, exp_ack});
    endtask

    task automatic header(input logic [15:0] a);
        sra_host_i.start();
        wr(dev_w(), 1'b1);
        wr(a[15:8], 1'b1);
        wr(a[7:0], 1'b1);
        check("busy", {31'h0, frame_active}, 32'h1);
    endtask

    task automatic write_words(input logic [15:0] a, input int n);
        logic [15:0] d;
        header(a);
        for (int i = 0; i < n; i++) begin
            d = (i == 1) ? 16'h0000 : rnd();
            mem[a + 16'(2 * i)] = d;
            exp_q.push_back({a + 16'(2 * i), d});
            wr(d[15:8], 1'b1);
            wr(d[7:0], 1'b1);
        end
        sra_host_i.stop();
        check("idle", {31'h0, frame_active}, 32'h0);
    endtask

    task automatic read_words(input logic [15:0] a, input logic rand_addr, input int n);
        logic [7:0] hi;
        logic [7:0] lo;
        if (rand_addr) header(a);
        sra_host_i.start();
        wr(dev_w() | 8'h01, 1'b1);
        for (int i = 0; i < n; i++) begin
            sra_host_i.rbyte(1'b0, hi);
            sra_host_i.rbyte(i == n - 1, lo);
            check("rd", {16'h0, hi, lo}, {16'h0, mem[a + 16'(2 * i)]});
        end
        sra_host_i.stop();
    endtask

    always @(negedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            miscompares++;
            complete_run();
        end
        if (upd.valid === 1'b1) begin
            check("upd", {upd.addr, upd.data}, exp_q.size() > 0 ? exp_q.pop_front() : 32'hX);
        end
    end

    initial begin
        logic [15:0] a;
        logic [15:0] b;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            @(posedge clock);
            addr_select_pin <= s[0];
            repeat (3) @(posedge clock);
            // host edges kept off the system clock edges
            #0.5;
            for (int k = 0; k < 2; k++) begin
                sra_host_i.start();
                wr(k ? 8'h7A : 8'h78, k == s);
                sra_host_i.stop();
            end
        end
        a = rnd() & 16'h003E;
        b = 16'h0040 | (rnd() & 16'h0030);
        write_words(a, 1);
        write_words(b, 3);
        header(a);
        wr(8'h5A, 1'b1);
        sra_host_i.stop();
        read_words(a, 1'b1, 1);
        read_words(b, 1'b1, 1);
        read_words(b + 16'h0002, 1'b0, 1);
        read_words(b + 16'h0004, 1'b0, 1);
        read_words(b, 1'b1, 3);
        repeat (20) @(posedge clock);
        check("pending", 32'(exp_q.size()), 32'h0);
        complete_run();
    end
endmodule // tb_serial_register_access_slave
